// [common/ext_bus_defines.svh]
// constants for the external bus strobe and wait controller
//
// Summary of operation
// RULE1 - upper lane enable low for word stores and high-byte stores, both widths; on the 8-bit bus the code asserts it for odd-address stores only
// RULE2 - strobe mode bit 1 selects upper lane enable, 0 high lane store strobe
// RULE3 - 16-bit bus: high lane store strobe on high-byte and word stores only
// RULE4 - 8-bit bus: high lane store strobe on every external store
// RULE5 - ready high sampled: cycle completes with no wait states
// RULE6 - ready sampled at bus clock falling edge; low inserts a wait state
// RULE7 - waits stop on ready high or when count reaches wait limit field
// RULE8 - ready ignored for internal accesses, used on external bus only
// RULE9 - ready honoured during configuration byte fetch before limit is loaded
// RULE10 - top bus bit is address-only on 8-bit bus, address/data on 16-bit
// RULE11 - low lane store strobe for low byte of word, every store on 8-bit bus
// RULE12 - companion pin is low lane strobe when mode 0, general store strobe mode 1
// RULE13 - read strobe only during external reads
// RULE14 - wait limit field is unsigned count of maximum wait states
// RULE15 - slow device drives ready low before falling edge while it needs time
`ifndef EXT_BUS_DEFINES_SVH
`define EXT_BUS_DEFINES_SVH
`define CFG_STROBE_MODE_BIT 2
`define CFG_WAIT_LO_BIT     4
`define CFG_WAIT_HI_BIT     5
`define CLK_DIV_HALF        2
`define BOOT_WAIT_LIMIT     2'h3
`endif

// [common/ext_bus_pkg.sv]
// types for the external bus strobe and wait controller
package ext_bus_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_DATA = 3'h3,
        ST_WAIT = 3'h2,
        ST_END  = 3'h6
    } bus_state_t;
endpackage : ext_bus_pkg

// [design/ext_bus_strobe_wait_ctrl.sv]
// external bus cycle sequencer with strobes and ready-driven waits
`timescale 1ns/1ns
`include "ext_bus_defines.svh"
module ext_bus_strobe_wait_ctrl (
    input  wire logic        CLOCK,
    input  wire logic        SRST,
    input  wire logic        REQ,
    input  wire logic        REQ_EXTERNAL,
    input  wire logic        REQ_WRITE,
    input  wire logic        REQ_WORD,
    input  wire logic [15:0] REQ_ADDR,
    input  wire logic [15:0] REQ_WDATA,
    input  wire logic        BUS_WIDTH16,
    input  wire logic        CFG_LOAD,
    input  wire logic [7:0]  CFG_BYTE,
    input  wire logic        READY,
    input  wire logic [15:0] AD_IN,
    output logic             DONE,
    output logic [15:0]      RDATA,
    output logic             BUSY,
    output logic             BUS_CLOCK_OUT,
    output logic [15:0]      AD_OUT,
    output logic [15:0]      AD_OE,
    output logic             ALE,
    output logic             RD_N,
    output logic             STROBE_LOW_N,
    output logic             STROBE_HIGH_N,
    output logic [1:0]       WAIT_COUNT
);
    // ************************************************************
    // state
    // ************************************************************
    ext_bus_pkg::bus_state_t st_q;
    ext_bus_pkg::bus_state_t st_d;
    logic        rdy_m_q;
    logic        rdy_s_q;
    logic        cfg_ok_q;
    logic        cfg_ok_d;
    logic        mode_q;
    logic        mode_d;
    logic [1:0]  lim_q;
    logic [1:0]  lim_d;
    logic [1:0]  wc_q;
    logic [1:0]  wc_d;
    logic        wr_q;
    logic        wr_d;
    logic        word_q;
    logic        word_d;
    logic        w16_q;
    logic        w16_d;
    logic [15:0] addr_q;
    logic [15:0] addr_d;
    logic [15:0] wdat_q;
    logic [15:0] wdat_d;
    logic [15:0] rdat_q;
    logic [15:0] rdat_d;
    logic        done_q;
    logic        done_d;
    logic        ale_q;
    logic        ale_d;
    logic        rd_q;
    logic        rd_d;
    logic        sl_q;
    logic        sl_d;
    logic        sh_q;
    logic        sh_d;
    logic        clk_q;
    logic        clk_d;
    logic        busy_q;
    logic        busy_d;
    logic [15:0] ado_q;
    logic [15:0] ado_d;
    logic [15:0] adoe_q;
    logic [15:0] adoe_d;
    logic        fall;
    logic [2:0]  strb;

    // ************************************************************
    // strobe decode: {read, low lane, high lane}, all active low
    // ************************************************************
    function automatic logic [2:0] strobe_decode(
        input logic wr,
        input logic word,
        input logic odd,
        input logic w16,
        input logic mode
    );
        logic hi;
        logic lo;
        logic [2:0] res;
        // upper byte involved: word store or odd address
        hi = wr && (word || odd);
        lo = wr && (word || !odd);
        res[2] = wr; // RULE13
        res[1] = !(wr && (mode || !w16 || lo)); // RULE11 RULE12
        res[0] = mode ? !(hi && w16 || wr && odd)   // RULE1
                      : !(w16 ? hi : wr);           // RULE3 RULE4
        return res;
    endfunction : strobe_decode

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        fall = clk_q;
        strb = strobe_decode(wr_q, word_q, addr_q[0], w16_q, mode_q);
        st_d = st_q;
        cfg_ok_d = cfg_ok_q;
        mode_d = mode_q;
        lim_d = lim_q;
        if (CFG_LOAD) begin
            cfg_ok_d = 1'b1;
            mode_d = CFG_BYTE[`CFG_STROBE_MODE_BIT]; // RULE2
            lim_d = {CFG_BYTE[`CFG_WAIT_HI_BIT], CFG_BYTE[`CFG_WAIT_LO_BIT]}; // RULE14
        end
        wc_d = wc_q;
        wr_d = wr_q;
        word_d = word_q;
        w16_d = w16_q;
        addr_d = addr_q;
        wdat_d = wdat_q;
        rdat_d = rdat_q;
        done_d = 1'b0;
        ale_d = 1'b0;
        rd_d = 1'b1;
        sl_d = 1'b1;
        sh_d = 1'b1;
        // bus clock rests low outside a bus cycle
        clk_d = (st_q == ext_bus_pkg::ST_IDLE || st_q == ext_bus_pkg::ST_END) ? 1'b0 : !clk_q;
        ado_d = ado_q;
        adoe_d = 16'h0000;
        case (st_q)
            ext_bus_pkg::ST_IDLE: begin
                if (REQ) begin
                    wr_d = REQ_WRITE;
                    word_d = REQ_WORD;
                    w16_d = BUS_WIDTH16;
                    addr_d = REQ_ADDR;
                    wdat_d = REQ_WDATA;
                    wc_d = 2'h0;
                    if (REQ_EXTERNAL) begin
                        st_d = ext_bus_pkg::ST_ADDR;
                        ale_d = 1'b1;
                        ado_d = REQ_ADDR;
                        adoe_d = 16'hFFFF;
                    end else begin
                        done_d = 1'b1; // RULE8
                    end
                end
            end
            ext_bus_pkg::ST_ADDR: begin
                st_d = ext_bus_pkg::ST_DATA;
                // strobes open with the data phase so the fall samples a driven bus
                rd_d = strb[2];
                sl_d = strb[1];
                sh_d = strb[0];
                // RULE10
                adoe_d = w16_q ? (wr_q ? 16'hFFFF : 16'h0000) : (wr_q ? 16'hFFFF : 16'hFF00);
                ado_d = w16_q ? wdat_q : {addr_q[15:8], (addr_q[0] ? wdat_q[15:8] : wdat_q[7:0])};
            end
            ext_bus_pkg::ST_DATA, ext_bus_pkg::ST_WAIT: begin
                adoe_d = adoe_q;
                rd_d = strb[2];
                sl_d = strb[1];
                sh_d = strb[0];
                if (fall) begin
                    // RULE6 RULE7 RULE9 - before config load the boot limit applies
                    if (!rdy_s_q && wc_q < (cfg_ok_q ? lim_q : `BOOT_WAIT_LIMIT)) begin
                        wc_d = wc_q + 2'h1;
                        st_d = ext_bus_pkg::ST_WAIT;
                    end else begin
                        st_d = ext_bus_pkg::ST_END; // RULE5
                        if (!wr_q) begin
                            rdat_d = w16_q ? AD_IN : {8'h00, AD_IN[7:0]};
                        end
                    end
                end
            end
            ext_bus_pkg::ST_END: begin
                done_d = 1'b1;
                st_d = ext_bus_pkg::ST_IDLE;
            end
            default: begin
                st_d = ext_bus_pkg::ST_IDLE;
            end
        endcase
        busy_d = (st_d != ext_bus_pkg::ST_IDLE);
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge CLOCK) begin
        rdy_m_q <= READY;
        rdy_s_q <= rdy_m_q;
        if (SRST) begin
            st_q <= ext_bus_pkg::ST_IDLE;
            cfg_ok_q <= 1'b0;
            mode_q <= 1'b0;
            lim_q <= 2'h0;
            wc_q <= 2'h0;
            wr_q <= 1'b0;
            word_q <= 1'b0;
            w16_q <= 1'b0;
            addr_q <= 16'h0000;
            wdat_q <= 16'h0000;
            rdat_q <= 16'h0000;
            done_q <= 1'b0;
            ale_q <= 1'b0;
            rd_q <= 1'b1;
            sl_q <= 1'b1;
            sh_q <= 1'b1;
            clk_q <= 1'b0;
            busy_q <= 1'b0;
            ado_q <= 16'h0000;
            adoe_q <= 16'h0000;
        end else begin
            st_q <= st_d;
            cfg_ok_q <= cfg_ok_d;
            mode_q <= mode_d;
            lim_q <= lim_d;
            wc_q <= wc_d;
            wr_q <= wr_d;
            word_q <= word_d;
            w16_q <= w16_d;
            addr_q <= addr_d;
            wdat_q <= wdat_d;
            rdat_q <= rdat_d;
            done_q <= done_d;
            ale_q <= ale_d;
            rd_q <= rd_d;
            sl_q <= sl_d;
            sh_q <= sh_d;
            clk_q <= clk_d;
            busy_q <= busy_d;
            ado_q <= ado_d;
            adoe_q <= adoe_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign DONE = done_q;
    assign RDATA = rdat_q;
    assign BUSY = busy_q;
    assign BUS_CLOCK_OUT = clk_q;
    assign AD_OUT = ado_q;
    assign AD_OE = adoe_q;
    assign ALE = ale_q;
    assign RD_N = rd_q;
    assign STROBE_LOW_N = sl_q;
    assign STROBE_HIGH_N = sh_q;
    assign WAIT_COUNT = wc_q;
endmodule : ext_bus_strobe_wait_ctrl

// [tb/ext_bus_asserts.sv]
// checker for the external bus strobe and wait controller
`timescale 1ns/1ns
module ext_bus_asserts (
    input wire logic        CLOCK, SRST, REQ, REQ_EXTERNAL, READY, DONE, BUSY, ALE, RD_N,
    input wire logic        STROBE_LOW_N,
    input wire logic [15:0] AD_OE
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SRST);
    done_pulse_a: assert property (DONE |=> !DONE) else $error("done longer than one cycle");
    no_wait_a: assert property (REQ && !BUSY && REQ_EXTERNAL && READY |-> ##4 DONE)
        else $error("ready cycle not finished in four cycles");
    wait_in_a: assert property (REQ && !BUSY && REQ_EXTERNAL && !READY |=> !DONE [*5])
        else $error("slow cycle finished without a wait");
    wait_bound_a: assert property (REQ && !BUSY && REQ_EXTERNAL |-> ##[1:11] DONE)
        else $error("waits exceed the largest limit");
    int_fast_a: assert property (REQ && !BUSY && !REQ_EXTERNAL |=> DONE && RD_N)
        else $error("internal access used the bus");
    rd_no_store_a: assert property (!RD_N |-> STROBE_LOW_N)
        else $error("store strobe during read");
    rd_release_a: assert property (!RD_N |-> AD_OE[7:0] == 8'h00)
        else $error("low lane driven during read");
    ale_addr_a: assert property (ALE |-> AD_OE == 16'hFFFF)
        else $error("address not driven on all bits");
    cover property (!RD_N);
    cover property (!STROBE_LOW_N);
    cover property (REQ && !BUSY && REQ_EXTERNAL ##1 !READY [*3]);
endmodule : ext_bus_asserts
bind ext_bus_strobe_wait_ctrl ext_bus_asserts u_chk (.*);

// [tb/slow_mem_model.sv]
// slow external memory that holds ready low for a set number of cycles
`timescale 1ns/1ns
module slow_mem_model (
    input wire logic        CLOCK, busy, rd_n,
    input wire logic [3:0]  stall,
    input wire logic [15:0] word,
    output logic            ready,
    output logic [15:0]     ad_in
);
    logic [3:0] cnt_q;
    always_ff @(posedge CLOCK) cnt_q <= busy ? cnt_q + {3'h0, cnt_q != 4'hF} : 4'h0;
    // ready already reflects the stall before the cycle starts
    assign ready = cnt_q >= stall;
    // released bus shows the inverse so a stale value never passes
    assign ad_in = rd_n ? ~word : word;
endmodule : slow_mem_model

// [tb/testbench.sv]
// self-checking bench for the external bus strobe and wait controller
`timescale 1ns/1ns
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
    $display("Error %s expected %0h seen %0h", n, e, g); end end
module testbench;
    logic CLOCK = 0, SRST = 1, REQ = 0, REQ_EXTERNAL = 0, REQ_WRITE = 0, REQ_WORD = 0;
    logic BUS_WIDTH16 = 0, CFG_LOAD = 0, READY, DONE, BUSY, BUS_CLOCK_OUT, ALE, RD_N;
    logic STROBE_LOW_N, STROBE_HIGH_N, hi_s, lo_s, rd_s, oeh_s;
    logic [15:0] REQ_ADDR = 0, REQ_WDATA = 16'h3C5A, AD_IN, RDATA, AD_OUT, AD_OE;
    logic [7:0] CFG_BYTE = 0;
    logic [15:0] adr_s;
    int clk_n;
    logic [3:0] stall = 0;
    logic [1:0] WAIT_COUNT;
    int fails = 0, total_checks = 0, lat;
    ext_bus_strobe_wait_ctrl u_dut (.*);
    slow_mem_model u_mem (.CLOCK, .busy(BUSY), .rd_n(RD_N), .stall, .word(16'hA55A),
        .ready(READY), .ad_in(AD_IN));
    initial forever #5 CLOCK = ~CLOCK;
    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done
    task automatic cfg(input logic [7:0] b);
        @(posedge CLOCK);
        CFG_LOAD <= 1'b1;
        CFG_BYTE <= b;
        @(posedge CLOCK);
        CFG_LOAD <= 1'b0;
    endtask : cfg
    task automatic acc(input logic e, w, wd, a0, b16);
        @(posedge CLOCK);
        REQ <= 1'b1; REQ_EXTERNAL <= e; REQ_WRITE <= w; REQ_WORD <= wd;
        REQ_ADDR <= {15'h1A2B, a0}; BUS_WIDTH16 <= b16;
        @(posedge CLOCK);
        REQ <= 1'b0;
        hi_s = 1; lo_s = 1; rd_s = 1; oeh_s = 1; lat = 0; adr_s = 0; clk_n = 0;
        do begin
            @(negedge CLOCK);
            lat++; hi_s &= STROBE_HIGH_N; lo_s &= STROBE_LOW_N; rd_s &= RD_N;
            if (ALE) adr_s = AD_OUT;
            clk_n += BUS_CLOCK_OUT;
            oeh_s &= RD_N | (&AD_OE[15:8]);
        end while (DONE !== 1'b1 && lat < 40);
    endtask : acc
    task automatic t_boot;
        stall <= 4'hF;
        acc(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
        `CHK("boot_lat", 10, lat)
        `CHK("boot_waits", 2'h3, WAIT_COUNT)
        stall <= 4'h0;
    endtask : t_boot
    task automatic t_internal;
        acc(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        `CHK("int_lat", 1, lat)
        `CHK("int_rd", 1'b1, rd_s)
    endtask : t_internal
    task automatic t_read;
        acc(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
        `CHK("rd_lat", 4, lat)
        `CHK("rd16", 16'hA55A, RDATA)
        `CHK("rd_strobe", 1'b0, rd_s)
        `CHK("ale_addr", 16'h3456, adr_s)
        `CHK("clk_hi", 1, clk_n)
        `CHK("oe_hi16", 1'b0, oeh_s)
        acc(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        `CHK("rd8", 16'h005A, RDATA)
        `CHK("oe_hi8", 1'b1, oeh_s)
        `CHK("rd_lo", 1'b1, lo_s)
    endtask : t_read
    task automatic t_strobes;
        logic b16, wd, a0;
        for (int m = 0; m < 2; m++) begin
            cfg(m ? 8'h04 : 8'h00);
            for (int i = 0; i < 8; i++) begin
                {b16, wd, a0} = i[2:0];
                if (!(wd && (a0 || (m && !b16)))) begin
                    acc(1'b1, 1'b1, wd, a0, b16);
                    `CHK("hi_n", !(b16 ? wd | a0 : m ? a0 : 1'b1), hi_s)
                    `CHK("lo_n", !(m ? 1'b1 : !b16 | wd | !a0), lo_s)
                    `CHK("wr_rd", 1'b1, rd_s)
                end
            end
        end
    endtask : t_strobes
    task automatic t_limit;
        cfg(8'h10);
        stall <= 4'hF;
        acc(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
        `CHK("lim1_lat", 6, lat)
        cfg(8'h30);
        stall <= 4'h3;
        acc(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
        `CHK("early_stop", 8, lat)
    endtask : t_limit
    initial begin
        repeat (3) @(posedge CLOCK);
        SRST <= 1'b0;
        t_boot; t_internal; t_read; t_strobes; t_limit;
        test_done;
    end
    initial begin
        #100000;
        fails++;
        test_done;
    end
endmodule : testbench
